// >>> design/adc_cal_pkg.sv
// Package of register map, field layout and carrier types for offset calibration
package adc_cal_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFFSET_CORRECTION_ADDR = 8'h18;
  localparam logic [7:0] CONTROL_ADDR = 8'h1c;
  localparam logic [7:0] RESULT_BASE_ADDR = 8'h20;
  localparam logic [7:0] RAW_STATUS_ADDR = 8'h60;
  localparam int unsigned NUM_CHANNELS = 16;
  localparam int unsigned RESULT_W = 10;
  localparam logic [9:0] CORRECTION_RESET = 10'h000;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam int unsigned CTRL_CAL_EN_BIT = 0;
  localparam int unsigned CTRL_BRIDGE_BIT = 1;
  localparam int unsigned CTRL_REF_LEVEL_BIT = 2;
  localparam int unsigned CTRL_CONV_EN_BIT = 5;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_0027;

  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [9:0] value;
  } conv_result_t;

  typedef struct packed {
    logic cal_en;
    logic bridge_sel;
    logic reference_level_select;
    logic conv_en;
  } control_t;

  typedef enum logic [1:0] {
    REF_LOW_NO_BRIDGE = 2'b00,
    REF_HIGH_NO_BRIDGE = 2'b01,
    REF_LOW_BRIDGE = 2'b10,
    REF_HIGH_BRIDGE = 2'b11
  } cal_ref_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b10
  } apb_phase_t;
endpackage

// >>> design/offset_adder.sv
// Offset adder: raw result plus two's complement correction, truncated
`timescale 1ns/10ps
module offset_adder
  import adc_cal_pkg::*;
(
  raw_value,
  correction_value,
  corrected_value
);
  input wire logic [RESULT_W-1:0] raw_value;
  input wire logic [RESULT_W-1:0] correction_value;
  output logic [RESULT_W-1:0] corrected_value;

  logic [RESULT_W:0] sum_full;

  // Wraps on overflow; no saturation is applied
  always_comb
  begin
    sum_full = {1'b0, raw_value} + {1'b0, correction_value};
    corrected_value = sum_full[RESULT_W-1:0];
  end
endmodule // offset_adder

// >>> design/result_bank.sv
// Bank of per-channel result registers
`timescale 1ns/10ps
module result_bank
  import adc_cal_pkg::*;
(
  pclk,
  presetn,
  wr_en,
  wr_channel,
  wr_value,
  rd_channel,
  rd_value
);
  input wire logic pclk;
  input wire logic presetn;
  input wire logic wr_en;
  input wire logic [3:0] wr_channel;
  input wire logic [RESULT_W-1:0] wr_value;
  input wire logic [3:0] rd_channel;
  output logic [RESULT_W-1:0] rd_value;

  logic [RESULT_W-1:0] result_value_r [NUM_CHANNELS];
  logic [RESULT_W-1:0] result_value_nxt [NUM_CHANNELS];

  always_comb
  begin
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      result_value_nxt[i] = result_value_r[i];
    end
    if (wr_en)
    begin
      result_value_nxt[wr_channel] = wr_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        result_value_r[i] <= RESULT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        result_value_r[i] <= result_value_nxt[i];
      end
    end
  end

  assign rd_value = result_value_r[rd_channel];
endmodule // result_bank

// >>> design/adc_offset_calibration.sv
// Offset calibration and correction stage with APB register slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module adc_offset_calibration
  import adc_cal_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire conv_result_t core_result,
  output logic cal_mode,
  output logic [1:0] cal_ref_sel,
  output logic conv_enable
);

  // ==========================================================
  // Register state
  logic [RESULT_W-1:0] correction_value_r;
  logic [RESULT_W-1:0] correction_value_nxt;
  control_t ctrl_r;
  control_t ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  conv_result_t core_q_r;
  logic [RESULT_W-1:0] last_raw_r;
  logic [RESULT_W-1:0] last_raw_nxt;

  logic [RESULT_W-1:0] corrected;
  logic store_en;
  logic [RESULT_W-1:0] bank_rd;
  logic [3:0] bank_rd_ch;

  logic setup;
  logic wr_cycle;
  logic rd_cycle;

  function automatic logic is_result_addr(input logic [ADDR_W-1:0] a);
    is_result_addr = (a >= RESULT_BASE_ADDR) &&
      (a < RESULT_BASE_ADDR + 8'(NUM_CHANNELS * 4)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFFSET_CORRECTION_ADDR) || (a == CONTROL_ADDR) ||
      (a == RAW_STATUS_ADDR) || is_result_addr(a);
  endfunction

  // Answer one cycle after setup; pready pulses in the access phase
  // Write lands only at the edge where the master sees pready high
  assign setup = psel && !penable;
  assign wr_cycle = psel && penable && pready_r && pwrite && is_mapped(paddr);
  assign rd_cycle = setup && !pwrite;
  assign bank_rd_ch = 4'((paddr - RESULT_BASE_ADDR) >> 2);

  // ==========================================================
  // Datapath
  offset_adder u_adder
  (
    .raw_value(core_q_r.value),
    .correction_value(correction_value_r),
    .corrected_value(corrected)
  );

  // Calibration conversions never reach the result bank
  assign store_en = core_q_r.valid && !ctrl_r.cal_en;

  result_bank u_bank
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(store_en),
    .wr_channel(core_q_r.channel),
    .wr_value(corrected),
    .rd_channel(bank_rd_ch),
    .rd_value(bank_rd)
  );

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    correction_value_nxt = correction_value_r;
    ctrl_nxt = ctrl_r;
    last_raw_nxt = last_raw_r;
    prdata_nxt = 32'h0000_0000;
    pready_nxt = setup;
    pslverr_nxt = setup && !is_mapped(paddr);
    if (wr_cycle && paddr == OFFSET_CORRECTION_ADDR)
    begin
      // Upper bits dropped; a write of zero clears the field
      correction_value_nxt = pwdata[RESULT_W-1:0];
    end
    if (wr_cycle && paddr == CONTROL_ADDR)
    begin
      // Converter enable does not touch the correction field
      ctrl_nxt.cal_en = pwdata[CTRL_CAL_EN_BIT];
      ctrl_nxt.bridge_sel = pwdata[CTRL_BRIDGE_BIT];
      ctrl_nxt.reference_level_select = pwdata[CTRL_REF_LEVEL_BIT];
      ctrl_nxt.conv_en = pwdata[CTRL_CONV_EN_BIT];
    end
    if (core_q_r.valid)
    begin
      last_raw_nxt = core_q_r.value;
    end
    // Conversion wins over a same-cycle software write in calibration mode
    if (core_q_r.valid && ctrl_r.cal_en)
    begin
      correction_value_nxt = core_q_r.value;
    end
    if (rd_cycle)
    begin
      if (paddr == OFFSET_CORRECTION_ADDR)
      begin
        prdata_nxt = {22'h000000, correction_value_r};
      end
      else if (paddr == CONTROL_ADDR)
      begin
        prdata_nxt[CTRL_CAL_EN_BIT] = ctrl_r.cal_en;
        prdata_nxt[CTRL_BRIDGE_BIT] = ctrl_r.bridge_sel;
        prdata_nxt[CTRL_REF_LEVEL_BIT] = ctrl_r.reference_level_select;
        prdata_nxt[CTRL_CONV_EN_BIT] = ctrl_r.conv_en;
      end
      else if (paddr == RAW_STATUS_ADDR)
      begin
        prdata_nxt = {22'h000000, last_raw_r};
      end
      else if (is_result_addr(paddr))
      begin
        prdata_nxt = {22'h000000, bank_rd};
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      correction_value_r <= CORRECTION_RESET;
      ctrl_r <= '0;
      last_raw_r <= RESULT_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      core_q_r <= '0;
    end
    else
    begin
      correction_value_r <= correction_value_nxt;
      ctrl_r <= ctrl_nxt;
      last_raw_r <= last_raw_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      core_q_r <= core_result;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cal_mode = ctrl_r.cal_en;
  assign cal_ref_sel = {ctrl_r.bridge_sel, ctrl_r.reference_level_select};
  assign conv_enable = ctrl_r.conv_en;

  // ==========================================================
  // Assertions
  AST_CAL_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    core_q_r.valid && ctrl_r.cal_en |=> correction_value_r == $past(core_q_r.value))
    else $error("Calibration conversion not captured");

  AST_NO_STORE_IN_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r.cal_en |-> !store_en)
    else $error("Result stored during calibration");

  AST_STORE_SUM: assert property (@(posedge pclk) disable iff (!presetn)
    store_en |-> corrected == 10'(core_q_r.value + correction_value_r))
    else $error("Corrected result is not the truncated sum");

  AST_ZERO_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    store_en && correction_value_r == CORRECTION_RESET |-> corrected == core_q_r.value)
    else $error("Zero correction changed the result");

  AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && paddr == OFFSET_CORRECTION_ADDR && !(core_q_r.valid && ctrl_r.cal_en)
    |=> correction_value_r == $past(pwdata[RESULT_W-1:0]))
    else $error("Correction write lost");

  AST_READ_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cycle && paddr == OFFSET_CORRECTION_ADDR |=> pready && prdata[31:10] == 22'h0)
    else $error("Reserved correction bits not zero");

  AST_READ_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cycle && paddr == OFFSET_CORRECTION_ADDR |=> prdata[9:0] == $past(correction_value_r))
    else $error("Correction read mismatch");

  AST_CONV_EN_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && paddr == CONTROL_ADDR && !core_q_r.valid
    |=> correction_value_r == $past(correction_value_r))
    else $error("Control write disturbed correction");

  AST_REF_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && paddr == CONTROL_ADDR
    |=> cal_ref_sel == {$past(pwdata[CTRL_BRIDGE_BIT]), $past(pwdata[CTRL_REF_LEVEL_BIT])})
    else $error("Reference select not applied");

  AST_STORE_BANK: assert property (@(posedge pclk) disable iff (!presetn)
    store_en |=> u_bank.result_value_r[$past(core_q_r.channel)] == $past(corrected))
    else $error("Result register not updated");

endmodule // adc_offset_calibration

// >>> verification/conv_core_model.sv
// Behavioural model of the converter core feeding raw results
`timescale 1ns/10ps
module conv_core_model
  import adc_cal_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cal_mode,
  input wire logic [1:0] cal_ref_sel,
  input wire logic conv_enable,
  input wire logic start,
  input wire logic [3:0] start_channel,
  input wire logic [9:0] sample,
  output conv_result_t core_result
);
  // ==========================================
  // Conversion output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_result <= '0;
    end
    else if (start && conv_enable)
    begin
      core_result.valid <= 1'b1;
      core_result.channel <= start_channel;
      // Reference code per source, distinct for each selection
      core_result.value <= cal_mode ? {cal_ref_sel, 8'h3c} : sample;
    end
    else
    begin
      // Stale value is scrambled so nobody can rely on it
      core_result.valid <= 1'b0;
      core_result.value <= ~core_result.value;
    end
  end
endmodule // conv_core_model

// >>> verification/adc_offset_calibration_tb_top.sv
// Self-checking testbench for the offset calibration stage
`timescale 1ns/10ps
module adc_offset_calibration_tb_top
  import adc_cal_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  conv_result_t core_result;
  logic cal_mode;
  logic [1:0] cal_ref_sel;
  logic conv_enable;
  logic start = 1'b0;
  logic [3:0] start_channel = 4'h0;
  logic [9:0] sample = 10'h000;
  int n_mismatch = 0;
  int tests_run = 0;

  always #25 pclk = ~pclk;

  adc_offset_calibration dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_result(core_result),
    .cal_mode(cal_mode), .cal_ref_sel(cal_ref_sel), .conv_enable(conv_enable));

  conv_core_model core_u (.pclk(pclk), .presetn(presetn), .cal_mode(cal_mode),
    .cal_ref_sel(cal_ref_sel), .conv_enable(conv_enable), .start(start),
    .start_channel(start_channel), .sample(sample), .core_result(core_result));

  // ==========================================
  // Bus and compare tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready mid-cycle, where it has settled
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge pclk);
    end
    if (n >= 50)
    begin
      n_mismatch++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check(what, exp, d);
  endtask

  // Result lands two edges after the request is seen by the core
  task automatic conv(input logic [3:0] ch, input logic [9:0] smp);
    start <= 1'b1;
    start_channel <= ch;
    sample <= smp;
    @(posedge pclk);
    start <= 1'b0;
    sample <= ~smp;
    repeat (3) @(posedge pclk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    rdchk("corr reset", OFFSET_CORRECTION_ADDR, 32'h0);
    wr(OFFSET_CORRECTION_ADDR, 32'hffff_ffff);
    rdchk("corr reserved", OFFSET_CORRECTION_ADDR, 32'h0000_03ff);
    wr(OFFSET_CORRECTION_ADDR, 32'h0);
    rdchk("corr cleared", OFFSET_CORRECTION_ADDR, 32'h0);
    apb(1'b0, 8'h04, 32'h0, d, e);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, d);
    $display("test registers done");
  endtask

  task automatic t_normal;
    logic [9:0] corr[3] = '{10'h000, 10'h010, 10'h3f0};
    logic [9:0] smp[3] = '{10'h155, 10'h3fa, 10'h100};
    logic [3:0] ch[3] = '{4'h0, 4'hf, 4'h7};
    wr(CONTROL_ADDR, 32'h0000_0020);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFFSET_CORRECTION_ADDR, {22'h0, corr[i]});
      conv(ch[i], smp[i]);
      rdchk("result", RESULT_BASE_ADDR + 8'(4 * ch[i]), {22'h0, smp[i] + corr[i]});
    end
    wr(CONTROL_ADDR, 32'h0);
    rdchk("corr kept", OFFSET_CORRECTION_ADDR, 32'h0000_03f0);
    $display("test normal done");
  endtask

  task automatic t_cal;
    logic [31:0] cap;
    logic [1:0] s;
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i);
      wr(CONTROL_ADDR, 32'h21 | {29'h0, s[0], s[1], 1'b0});
      check("ref sel", {30'h0, s}, {30'h0, cal_ref_sel});
      check("cal mode", 32'h1, {31'h0, cal_mode});
      conv(4'h3, 10'h2aa);
      rdchk("captured", OFFSET_CORRECTION_ADDR, {22'h0, s, 8'h3c});
    end
    rdchk("no result in cal", RESULT_BASE_ADDR + 8'h0c, 32'h0);
    wr(OFFSET_CORRECTION_ADDR, 32'h0000_0123);
    rdchk("sw write in cal", OFFSET_CORRECTION_ADDR, 32'h0000_0123);
    conv(4'h3, 10'h2aa);
    apb_cap(cap);
    check("overwritten", 32'h0000_033c, cap);
    wr(OFFSET_CORRECTION_ADDR, {22'h0, 10'h200 - cap[9:0]});
    wr(CONTROL_ADDR, 32'h0000_0020);
    rdchk("corr normal", OFFSET_CORRECTION_ADDR, {22'h0, 10'h200 - 10'h33c});
    conv(4'h5, 10'h33c);
    rdchk("calibrated", RESULT_BASE_ADDR + 8'h14, 32'h0000_0200);
    $display("test calibration done");
  endtask

  task automatic apb_cap(output logic [31:0] d);
    logic e;
    apb(1'b0, OFFSET_CORRECTION_ADDR, 32'h0, d, e);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_normal();
    t_cal();
    stop_test();
  end

  // Whole run needs about 140 cycles
  initial
  begin
    #(50 * 5000);
    n_mismatch++;
    stop_test();
  end
endmodule // adc_offset_calibration_tb_top
